/* File: inc/adtc_consts.svh */
// constants of the converter timing and clock select block
// assumes inclusion by the design modules and the bench by bare name
`ifndef ADTC_CONSTS_SVH
`define ADTC_CONSTS_SVH

// ----------------------------------------------------------------------
// register offsets (word index on the plain register port)
// ----------------------------------------------------------------------
`define ADTC_OFS_CTRL 4'h0
`define ADTC_OFS_ALTDIV 4'h1
`define ADTC_OFS_RESULT 4'h2
`define ADTC_OFS_STATUS 4'h3
`define ADTC_OFS_IRQ_STAT 4'h4
`define ADTC_OFS_IRQ_CLR 4'h5
`define ADTC_OFS_IRQ_EN 4'h6
`define ADTC_OFS_SYSCFG 4'h7
`define ADTC_OFS_MCLKGEN 4'h8

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define ADTC_CTRL_START 0
`define ADTC_CTRL_POSTCAL 1
`define ADTC_CTRL_RES8 2
`define ADTC_CTRL_IMPROVED 3
`define ADTC_DIVSEL_HI 15
`define ADTC_DIVSEL_LO 14
`define ADTC_SAMPSEL_HI 13
`define ADTC_SAMPSEL_LO 12
`define ADTC_IRQ_DONE 0
`define ADTC_IRQ_CAL 1

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define ADTC_CTRL_RST 16'h0002
`define ADTC_ALTDIV_RST 8'h01
`define ADTC_MCLKGEN_RST 2'h0

// ----------------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------------
`define ADTC_DIV_00 9'd4
`define ADTC_DIV_01 9'd2
`define ADTC_DIV_10 9'd16
`define ADTC_DIV_11 9'd8
`define ADTC_SAMP_00 8'd8
`define ADTC_SAMP_01 8'd16
`define ADTC_SAMP_10 8'd32
`define ADTC_SAMP_11 8'd64
`define ADTC_BITS10 4'd10
`define ADTC_BITS8 4'd8
`define ADTC_BC_PER_BIT 8'd4
`define ADTC_SAR10_BC 8'd40
`define ADTC_SAR8_BC 8'd32
`define ADTC_POSTCAL_BC 8'd12
`define ADTC_LOAD_SYS 3'd6
`define ADTC_CAL_MIN_BC 14'd484
`define ADTC_CAL_MAX_BC 11696

`endif

/* File: inc/adtc_pkg.sv */
// types shared by the converter timing modules
// assumes the constants header sits beside it
package adtc_pkg;
    // converter sequence phases
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SAMPLE,
        ST_CONVERT,
        ST_POSTCAL,
        ST_LOAD
    } adtc_state_e;
    typedef logic [15:0] adtc_word_t; // register port data word
endpackage : adtc_pkg

/* File: inc/adtc_tick_if.sv */
// clock-tick carrier between the control core and the clock generator
// assumes one clock domain, i_mclk, on both sides
`timescale 1ns/1ps
interface adtc_tick_if;
    logic halve; // cpu clock is master clock halved
    logic compat; // table prescaler in force
    logic restart; // realign basic clock prescaler
    logic [1:0] div_sel; // basic clock select
    logic [7:0] alt_div; // improved divider minus one
    logic sys_tick; // system clock edge
    logic cpu_tick; // cpu clock edge
    logic bc_tick; // basic clock edge
    modport gen(input halve, compat, restart, div_sel, alt_div,
                output sys_tick, cpu_tick, bc_tick);
    modport ctl(output halve, compat, restart, div_sel, alt_div,
                input sys_tick, cpu_tick, bc_tick);
endinterface : adtc_tick_if

/* File: hw/adtc_sync.sv */
// two-flop synchroniser for the asynchronous analog status inputs
// assumes inputs are levels that hold for several clocks
`timescale 1ns/1ps
module adtc_sync #(
    parameter int W = 4
) (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    // only the second stage is ever looked at
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } adtc_sync_s;
    adtc_sync_s q, n;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        n = q;
        n.s1 = i_d;
        n.s2 = q.s1;
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign o_q = q.s2;
endmodule : adtc_sync

/* File: hw/adtc_clkgen.sv */
// cpu, system and converter basic clock tick generator
// assumes the master clock is the module clock; ticks are enables
`timescale 1ns/1ps
`include "adtc_consts.svh"
module adtc_clkgen import adtc_pkg::*; (
    input wire logic i_mclk,
    input wire logic i_nrst,
    adtc_tick_if.gen tk
);
    typedef struct packed {
        logic ph; // halving phase
        logic [8:0] bcnt; // system ticks into basic period
        logic sys; // system/cpu tick flop
        logic bc; // basic clock tick flop
    } adtc_cg_s;
    adtc_cg_s q, n;

    // prescaler divisor; improved mode takes the free divider
    function automatic logic [8:0] div_of(input logic compat,
            input logic [1:0] sel, input logic [7:0] alt);
        if (!compat) begin
            div_of = {1'b0, alt} + 9'd1;
        end else begin
            case (sel)
                2'b00: div_of = `ADTC_DIV_00;
                2'b01: div_of = `ADTC_DIV_01;
                2'b10: div_of = `ADTC_DIV_10;
                default: div_of = `ADTC_DIV_11;
            endcase
        end
    endfunction : div_of

    // ------------------------------------------------------------------
    // tick generation
    // ------------------------------------------------------------------
    always_comb begin
        n = q;
        // cpu and system share one tick, so frequencies are equal
        n.ph = tk.halve ? ~q.ph : 1'b0;
        n.sys = ~tk.halve | q.ph;
        n.bc = 1'b0;
        if (tk.restart) begin
            // realign so a sample starts on a whole basic period
            n.bcnt = 9'd0;
        end else if (n.sys) begin
            if (q.bcnt >= div_of(tk.compat, tk.div_sel, tk.alt_div)
                    - 9'd1) begin
                n.bcnt = 9'd0;
                n.bc = 1'b1;
            end else begin
                n.bcnt = q.bcnt + 9'd1;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign tk.sys_tick = q.sys;
    assign tk.cpu_tick = q.sys;
    assign tk.bc_tick = q.bc;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    bc_div_four_a: assert property (
        @(posedge i_mclk) disable iff (!i_nrst || tk.restart)
        (q.bc && tk.compat && !tk.halve && tk.div_sel == 2'b00)
        |=> !q.bc [*3] ##1 q.bc)
        else $error("basic clock is not system clock over four");
    cpu_halve_a: assert property (
        @(posedge i_mclk) disable iff (!i_nrst)
        (tk.halve && q.sys) |=> !q.sys ##1 q.sys)
        else $error("halved cpu tick does not alternate");
endmodule : adtc_clkgen

/* File: hw/adtc_top.sv */
// converter timing control: prescaler, sequencing, calibration, clocks
// assumes a plain register port and synchronous master clock i_mclk
`timescale 1ns/1ps
`include "adtc_consts.svh"
// Functional notes
// - basic clock select divides by 4,2,16,8
// - sample time 8,16,32,64 basic periods
// - ten-bit: 52 or 40 periods plus extras
// - eight-bit: 44 or 32 periods plus extras
// - post-calibration off saves exactly 12 periods
// - sample, determine, then load over system clocks
// - reset calibration lasts 484 to 11696 periods
// - conversions during calibration run, extend it
// - out-of-range input saturates to zeros/ones
// - table prescaler in compatibility, improved selectable
// - cpu clock is master or half
// - core and bus controller use cpu clock
// - system clock equals cpu clock frequency
// - master clock generation chosen by register
module adtc_top import adtc_pkg::*; #(
    parameter int CAL_MAX_BC = `ADTC_CAL_MAX_BC
) (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic [3:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    input wire logic i_ain_cmp,
    input wire logic i_ain_below,
    input wire logic i_ain_above,
    input wire logic i_ref_settled,
    output logic o_sample,
    output logic [9:0] o_trial,
    output logic o_irq,
    output logic o_cpu_tick,
    output logic o_sys_tick,
    output logic o_cpu_halve,
    output logic [1:0] o_mclk_gen_sel
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        adtc_state_e st; // conversion phase
        adtc_word_t ctrl; // converter control register
        logic [7:0] altd; // improved divider
        logic [9:0] res; // result register
        logic [9:0] trial; // successive approximation word
        logic [3:0] k; // bits decided so far
        logic [7:0] cnt; // basic periods in phase
        logic post; // latched post-calibration enable
        logic res8; // latched eight-bit mode
        logic [1:0] ssel; // latched sample select
        logic s_lo; // input below ground at sample end
        logic s_hi; // input above supply at sample end
        logic cal; // reset calibration running
        logic [13:0] calc; // calibration basic periods
        logic [1:0] ist; // sticky event status
        logic [1:0] ien; // event enables
        logic halve; // cpu clock halving select
        logic [1:0] mgen; // master clock generation select
        adtc_word_t rdata; // read data flop
        logic irq; // interrupt flop
        logic samp_o; // sample switch flop
        logic restart; // prescaler realign pulse
        logic done; // result load pulse
        logic [7:0] hbc; // basic periods since start
        logic [2:0] hsys; // system ticks in load
    } adtc_top_s;
    adtc_top_s q, n;

    adtc_tick_if tk ();
    logic [3:0] syn; // synchronised analog status
    logic bc; // usable basic clock tick
    logic start; // accepted start request
    logic [1:0] clr; // status bits cleared by software

    // sample length in basic periods
    function automatic logic [7:0] samp_len(input logic [1:0] sel);
        case (sel)
            2'b00: samp_len = `ADTC_SAMP_00;
            2'b01: samp_len = `ADTC_SAMP_01;
            2'b10: samp_len = `ADTC_SAMP_10;
            default: samp_len = `ADTC_SAMP_11;
        endcase
    endfunction : samp_len

    // bits to decide for the resolution
    function automatic logic [3:0] sar_bits(input logic res8);
        sar_bits = res8 ? `ADTC_BITS8 : `ADTC_BITS10;
    endfunction : sar_bits

    // ------------------------------------------------------------------
    // surroundings
    // ------------------------------------------------------------------
    // comparator and range detectors are asynchronous to i_mclk
    adtc_sync #(.W(4)) u_sync (
        .i_mclk(i_mclk),
        .i_nrst(i_nrst),
        .i_d({i_ref_settled, i_ain_above, i_ain_below, i_ain_cmp}),
        .o_q(syn)
    );

    adtc_clkgen u_clkgen (
        .i_mclk(i_mclk),
        .i_nrst(i_nrst),
        .tk(tk)
    );

    assign tk.halve = q.halve;
    assign tk.compat = ~q.ctrl[`ADTC_CTRL_IMPROVED];
    assign tk.div_sel = q.ctrl[`ADTC_DIVSEL_HI:`ADTC_DIVSEL_LO];
    assign tk.alt_div = q.altd;
    assign tk.restart = q.restart;

    // a tick that left the prescaler before realignment is stale
    assign bc = tk.bc_tick & ~q.restart;
    assign start = i_wr && i_addr == `ADTC_OFS_CTRL
        && i_wdata[`ADTC_CTRL_START] && q.st == ST_IDLE;
    assign clr = (i_wr && i_addr == `ADTC_OFS_IRQ_CLR) ?
        i_wdata[1:0] : 2'b00;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        n = q;
        n.restart = 1'b0;
        n.done = 1'b0;
        n.rdata = 16'h0000;
        // register writes; start is a pulse and is not stored
        if (i_wr) begin
            case (i_addr)
                `ADTC_OFS_CTRL: begin
                    n.ctrl = i_wdata;
                    n.ctrl[`ADTC_CTRL_START] = 1'b0;
                end
                `ADTC_OFS_ALTDIV: n.altd = i_wdata[7:0];
                `ADTC_OFS_IRQ_EN: n.ien = i_wdata[1:0];
                `ADTC_OFS_SYSCFG: n.halve = i_wdata[0];
                `ADTC_OFS_MCLKGEN: n.mgen = i_wdata[1:0];
                default: ;
            endcase
        end
        // sticky events: clear first so a same-cycle set wins
        n.ist = q.ist & ~clr;
        // reset calibration advances only while no conversion runs
        if (q.cal && q.st == ST_IDLE && bc) begin
            n.calc = q.calc + 14'd1;
        end
        if (q.cal && ((q.calc >= `ADTC_CAL_MIN_BC && syn[3])
                || q.calc >= CAL_MAX_BC[13:0])) begin
            n.cal = 1'b0;
            n.ist[`ADTC_IRQ_CAL] = 1'b1;
        end
        // conversion sequence
        case (q.st)
            ST_IDLE: begin
                if (start) begin
                    n.st = ST_SAMPLE;
                    n.post = i_wdata[`ADTC_CTRL_POSTCAL];
                    n.res8 = i_wdata[`ADTC_CTRL_RES8];
                    n.ssel = i_wdata[`ADTC_SAMPSEL_HI:`ADTC_SAMPSEL_LO];
                    n.cnt = 8'd0;
                    n.hbc = 8'd0;
                    n.restart = 1'b1;
                    n.samp_o = 1'b1;
                    n.trial = 10'h000;
                end
            end
            ST_SAMPLE: begin
                if (bc) begin
                    n.cnt = q.cnt + 8'd1;
                    n.hbc = q.hbc + 8'd1;
                    if (q.cnt + 8'd1 == samp_len(q.ssel)) begin
                        n.st = ST_CONVERT;
                        n.samp_o = 1'b0;
                        n.s_lo = syn[1];
                        n.s_hi = syn[2];
                        n.cnt = 8'd0;
                        n.k = 4'd0;
                        n.trial = 10'h200;
                    end
                end
            end
            ST_CONVERT: begin
                if (bc) begin
                    n.cnt = q.cnt + 8'd1;
                    n.hbc = q.hbc + 8'd1;
                    // one bit decided per four basic periods
                    if (q.cnt == `ADTC_BC_PER_BIT - 8'd1) begin
                        n.cnt = 8'd0;
                        n.k = q.k + 4'd1;
                        if (!syn[0]) begin
                            n.trial[4'd9 - q.k] = 1'b0;
                        end
                        if (q.k + 4'd1 == sar_bits(q.res8)) begin
                            // skipping the trim saves twelve periods
                            n.st = q.post ? ST_POSTCAL : ST_LOAD;
                            n.hsys = 3'd0;
                        end else begin
                            n.trial[4'd8 - q.k] = 1'b1;
                        end
                    end
                end
            end
            ST_POSTCAL: begin
                if (bc) begin
                    n.cnt = q.cnt + 8'd1;
                    n.hbc = q.hbc + 8'd1;
                    if (q.cnt + 8'd1 == `ADTC_POSTCAL_BC) begin
                        n.st = ST_LOAD;
                        n.hsys = 3'd0;
                    end
                end
            end
            ST_LOAD: begin
                // load step counts system clocks, not basic periods
                if (tk.sys_tick) begin
                    n.hsys = q.hsys + 3'd1;
                    if (q.hsys + 3'd1 == `ADTC_LOAD_SYS) begin
                        if (q.s_lo) begin
                            n.res = 10'h000;
                        end else if (q.s_hi) begin
                            n.res = 10'h3FF;
                        end else begin
                            n.res = q.trial;
                        end
                        n.done = 1'b1;
                        n.ist[`ADTC_IRQ_DONE] = 1'b1;
                        n.st = ST_IDLE;
                    end
                end
            end
            default: n.st = ST_IDLE;
        endcase
        // read data valid only in the cycle after the strobe
        if (i_rd) begin
            case (i_addr)
                `ADTC_OFS_CTRL: n.rdata = q.ctrl;
                `ADTC_OFS_ALTDIV: n.rdata = {8'h00, q.altd};
                `ADTC_OFS_RESULT: n.rdata = {6'h00, q.res};
                `ADTC_OFS_STATUS: n.rdata = {12'h000, q.s_hi, q.s_lo,
                    q.cal, q.st != ST_IDLE};
                `ADTC_OFS_IRQ_STAT: n.rdata = {14'h0000, q.ist};
                `ADTC_OFS_IRQ_EN: n.rdata = {14'h0000, q.ien};
                `ADTC_OFS_SYSCFG: n.rdata = {15'h0000, q.halve};
                `ADTC_OFS_MCLKGEN: n.rdata = {14'h0000, q.mgen};
                default: n.rdata = 16'h0000;
            endcase
        end
        n.irq = |(n.ist & n.ien);
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            q <= '0;
            q.st <= ST_IDLE;
            q.ctrl <= `ADTC_CTRL_RST;
            q.altd <= `ADTC_ALTDIV_RST;
            q.mgen <= `ADTC_MCLKGEN_RST;
            q.cal <= 1'b1;
        end else begin
            q <= n;
        end
    end

    assign o_rdata = q.rdata;
    assign o_sample = q.samp_o;
    assign o_trial = q.trial;
    assign o_irq = q.irq;
    assign o_cpu_tick = tk.cpu_tick;
    assign o_sys_tick = tk.sys_tick;
    assign o_cpu_halve = q.halve;
    assign o_mclk_gen_sel = q.mgen;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sample_len_a: assert property (
        @(posedge i_mclk) disable iff (!i_nrst)
        (q.st == ST_SAMPLE && n.st == ST_CONVERT)
        |-> n.hbc == samp_len(q.ssel))
        else $error("sample phase length wrong");
    conv_ten_a: assert property (
        @(posedge i_mclk) disable iff (!i_nrst)
        (q.st != ST_LOAD && n.st == ST_LOAD && !q.res8)
        |-> n.hbc == samp_len(q.ssel) + `ADTC_SAR10_BC
            + (q.post ? `ADTC_POSTCAL_BC : 8'd0))
        else $error("ten-bit conversion length wrong");
    conv_eight_a: assert property (
        @(posedge i_mclk) disable iff (!i_nrst)
        (q.st != ST_LOAD && n.st == ST_LOAD && q.res8)
        |-> n.hbc == samp_len(q.ssel) + `ADTC_SAR8_BC
            + (q.post ? `ADTC_POSTCAL_BC : 8'd0))
        else $error("eight-bit conversion length wrong");
    postcal_skip_a: assert property (
        @(posedge i_mclk) disable iff (!i_nrst)
        (q.st != ST_LOAD && n.st == ST_LOAD)
        |-> (q.post ? q.st == ST_POSTCAL : q.st == ST_CONVERT))
        else $error("post-calibration taken wrongly");
    phase_order_a: assert property (
        @(posedge i_mclk) disable iff (!i_nrst)
        q.st == ST_SAMPLE |=> q.st inside {ST_SAMPLE, ST_CONVERT})
        else $error("sample not followed by conversion");
    load_sys_a: assert property (
        @(posedge i_mclk) disable iff (!i_nrst)
        q.done |-> q.hsys == `ADTC_LOAD_SYS && $past(q.st) == ST_LOAD)
        else $error("load step length wrong");
    cal_len_a: assert property (
        @(posedge i_mclk) disable iff (!i_nrst)
        $fell(q.cal) |-> $past(q.calc) >= `ADTC_CAL_MIN_BC
            && $past(q.calc) <= CAL_MAX_BC[13:0])
        else $error("calibration length out of range");
    cal_hold_a: assert property (
        @(posedge i_mclk) disable iff (!i_nrst)
        (q.cal && q.st != ST_IDLE) |=> $stable(q.calc))
        else $error("calibration advanced during conversion");
    sat_range_a: assert property (
        @(posedge i_mclk) disable iff (!i_nrst)
        q.done |-> (q.s_lo ? q.res == 10'h000
            : (!q.s_hi || q.res == 10'h3FF)))
        else $error("out-of-range result not saturated");
    done_flag_a: assert property (
        @(posedge i_mclk) disable iff (!i_nrst)
        (q.done || $rose(q.ist[`ADTC_IRQ_DONE])) |-> q.done
            && q.ist[`ADTC_IRQ_DONE] && $past(q.st) == ST_LOAD)
        else $error("done flag not with result load");
endmodule : adtc_top

/* File: tb/adtc_ain_model.sv */
// analog input model: comparator and range flags around a set voltage
// assumes the trial word is held while the comparator is sampled
`timescale 1ns/1ps
module adtc_ain_model (
    input wire logic [9:0] i_trial,
    input wire logic [9:0] i_vin,
    input wire logic i_lo,
    input wire logic i_hi,
    input wire logic i_quiet,
    output logic o_cmp,
    output logic o_below,
    output logic o_above,
    output logic o_settled
);
    // ideal comparator; a rail fault forces every decision toward that rail
    assign o_cmp = i_hi | (!i_lo & (i_vin >= i_trial));
    assign o_below = i_lo;
    assign o_above = i_hi;
    // reference noise gate for the reset calibration
    assign o_settled = i_quiet;
endmodule : adtc_ain_model

/* File: tb/adc_timing_and_clock_select_test.sv */
// self-checking bench: register port tasks and timed conversions
// assumes the design package, header and analog model are compiled first
`timescale 1ns/1ps
`include "adtc_consts.svh"
module adc_timing_and_clock_select_test import adtc_pkg::*;;
    logic i_mclk = 0, i_nrst = 0, i_wr = 0, i_rd = 0;
    logic [3:0] i_addr = 4'h0;
    adtc_word_t i_wdata = 16'h0, o_rdata;
    logic [9:0] vin = 10'h2A5, o_trial; // held analog level
    logic lo = 0, hi = 0, quiet = 0, cmp, below, above, settled;
    logic o_sample, o_irq, o_cpu_tick, o_sys_tick, o_cpu_halve;
    logic [1:0] o_mclk_gen_sel;
    int bad_count = 0, total_checks = 0;
    int samp_n; // cycles with the sample switch closed
    initial begin
        forever #12.5 i_mclk = ~i_mclk;
    end
    // short calibration ceiling keeps the run brief
    adtc_top #(.CAL_MAX_BC(600)) dut_u (.i_mclk(i_mclk), .i_nrst(i_nrst),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_ain_cmp(cmp), .i_ain_below(below),
        .i_ain_above(above), .i_ref_settled(settled), .o_sample(o_sample),
        .o_trial(o_trial), .o_irq(o_irq), .o_cpu_tick(o_cpu_tick),
        .o_sys_tick(o_sys_tick), .o_cpu_halve(o_cpu_halve),
        .o_mclk_gen_sel(o_mclk_gen_sel));
    adtc_ain_model mdl_u (.i_trial(o_trial), .i_vin(vin), .i_lo(lo),
        .i_hi(hi), .i_quiet(quiet), .o_cmp(cmp), .o_below(below),
        .o_above(above), .o_settled(settled));
    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task finish_test;
        $display("checks %0d errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : finish_test
    task chk(input adtc_word_t seen, input adtc_word_t exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk
    // one-cycle write strobe beside address and data
    task wr(input logic [3:0] a, input adtc_word_t d);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask : wr
    // data stand only in the cycle after the strobe edge
    task rd(input logic [3:0] a, output adtc_word_t d);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask : rd
    // start with done flag cleared, count cycles to the interrupt
    task conv(input adtc_word_t ctrl, output int n);
        n = 0;
        samp_n = 0;
        wr(`ADTC_OFS_IRQ_CLR, 16'h0001);
        wr(`ADTC_OFS_CTRL, ctrl | 16'h0001);
        while (o_irq !== 1'b1 && n < 5000) begin
            @(posedge i_mclk);
            // look after the edge so the flops have settled
            #1 n++;
            samp_n += int'(o_sample === 1'b1);
        end
        if (n >= 5000) begin
            bad_count++;
            finish_test();
        end
    endtask : conv
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        int n, n0, e;
        adtc_word_t v;
        adtc_word_t ctl [8];
        int dv [8];
        // every divider and sample code; basic clock kept at 20 MHz max
        ctl = '{16'h4002, 16'h4000, 16'h4006, 16'h5004, 16'hC000,
                16'h2002, 16'h8000, 16'h3008};
        dv = '{2, 2, 2, 2, 8, 4, 16, 3};
        repeat (8) @(posedge i_mclk);
        i_nrst <= 1'b1;
        rd(`ADTC_OFS_CTRL, v); chk(v, 16'h0002);
        rd(`ADTC_OFS_ALTDIV, v); chk(v, 16'h0001);
        rd(4'hF, v); chk(v, 16'h0000);
        rd(`ADTC_OFS_STATUS, v); chk(v & 16'h2, 16'h2);
        wr(`ADTC_OFS_ALTDIV, 16'h0002);
        wr(`ADTC_OFS_IRQ_EN, 16'h0001);
        for (int i = 0; i < 8; i++) begin
            conv(ctl[i], n);
            e = ((8 << ctl[i][13:12]) + (ctl[i][2] ? 32 : 40)
                + (ctl[i][1] ? 12 : 0)) * dv[i] + 8;
            chk(16'(n >= e - 4 && n <= e + 4), 16'h1);
            chk(16'(samp_n), 16'((8 << ctl[i][13:12]) * dv[i] + 1));
            if (i == 0) n0 = n;
            if (i == 1) chk(16'(n0 - n), 16'd24);
            rd(`ADTC_OFS_RESULT, v);
            chk(v, ctl[i][2] ? {6'h0, vin[9:2], 2'b00} : {6'h0, vin});
            // first conversion ran inside the reset calibration
            if (i == 0) begin
                rd(`ADTC_OFS_STATUS, v); chk(v & 16'h2, 16'h2);
            end
        end
        rd(`ADTC_OFS_IRQ_STAT, v); chk(v & 16'h1, 16'h1);
        // rail faults saturate the result
        lo <= 1'b1;
        conv(16'h4000, n);
        rd(`ADTC_OFS_RESULT, v); chk(v, 16'h0000);
        lo <= 1'b0;
        hi <= 1'b1;
        conv(16'h4000, n);
        rd(`ADTC_OFS_RESULT, v); chk(v, 16'h03FF);
        hi <= 1'b0;
        quiet <= 1'b1;
        n = 0;
        do begin
            rd(`ADTC_OFS_IRQ_STAT, v);
            n++;
        end while (v[1] !== 1'b1 && n < 2000);
        chk(v & 16'h2, 16'h2);
        // interrupt masked, enabled, then cleared
        wr(`ADTC_OFS_IRQ_EN, 16'h0000);
        repeat (2) @(posedge i_mclk);
        chk({15'h0, o_irq}, 16'h0);
        wr(`ADTC_OFS_IRQ_EN, 16'h0002);
        repeat (2) @(posedge i_mclk);
        chk({15'h0, o_irq}, 16'h1);
        wr(`ADTC_OFS_IRQ_CLR, 16'h0003);
        repeat (2) @(posedge i_mclk);
        chk({15'h0, o_irq}, 16'h0);
        rd(`ADTC_OFS_IRQ_STAT, v); chk(v, 16'h0000);
        rd(`ADTC_OFS_IRQ_CLR, v); chk(v, 16'h0000);
        // halved cpu clock: ticks every other cycle, system clock alike
        wr(`ADTC_OFS_MCLKGEN, 16'h0002);
        wr(`ADTC_OFS_SYSCFG, 16'h0001);
        repeat (3) @(posedge i_mclk);
        chk({14'h0, o_mclk_gen_sel}, 16'h2);
        chk({15'h0, o_cpu_halve}, 16'h1);
        n = 0;
        repeat (20) begin
            @(posedge i_mclk);
            #1 n += int'(o_sys_tick);
            chk({15'h0, o_cpu_tick}, {15'h0, o_sys_tick});
        end
        chk(16'(n), 16'd10);
        finish_test();
    end
endmodule : adc_timing_and_clock_select_test
